/* File: src/flog_top.sv */
// Fault and user event logger: sampler, ring buffer, log store, registers
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "flog_regs.svh"
// ==================================================================
// What this block does
// (RL1) Sample all parameters continuously at factory interval
// (RL2) After fault, post samples, freeze, store log
// (RL3) Keep twelve logs; newest replaces the oldest
// (RL4) Count of valid logs is readable
// (RL5) Log index zero is oldest, eleven newest
// (RL6) Header fetch loads header into window words
// (RL7) Header order: time, date, counts, period, post
// (RL8) Time stamp top byte unused, reads zero
// (RL9) Records numbered oldest first, full window span
// (RL10) Parameters sit at fixed window word offsets
// (RL11) Record fetch loads chosen record into window
// (RL12) User mode samples selected parameters; trigger freezes
// (RL13) Enable mask split into low and high registers
// (RL14) Enable bits 56 to 63 select nothing
// (RL15) Fetches are strobes; window holds afterwards
module flog_top #(
	parameter int          REC_DEPTH   = `FLOG_REC_DEPTH,
	parameter int          FIFO_DEPTH  = 4,
	parameter int          POST_SAMPLES = `FLOG_POST,
	parameter int          USER_POST   = `FLOG_POST,
	parameter logic [15:0] PERIOD_MS   = `FLOG_PERIOD_MS,
	parameter int          CYC_PER_MS  = `FLOG_CYC_PER_MS
) (
	input  wire logic                          clock_in,
	input  wire logic                          rst_in,
	input  wire logic [15:0]                   addr_in,
	input  wire logic [31:0]                   wr_data_in,
	input  wire logic                          wr_in,
	input  wire logic                          rd_in,
	output logic      [31:0]                   rd_data_out,
	input  wire logic [`FLOG_WIN_WORDS*16-1:0] param_words_in,
	input  wire logic [31:0]                   rtc_time_in,
	input  wire logic [31:0]                   rtc_date_in,
	input  wire logic                          fault_in,
	input  wire logic                          user_tick_in,
	input  wire logic                          user_trigger_in,
	output flog_pkg::flog_state_type           state_out,
	output logic                               sample_stall_out
);
	import flog_pkg::*;
	localparam int REC_W = `FLOG_WIN_WORDS * 16;
	localparam int HDR_W = `FLOG_HDR_WORDS * 16;
	localparam int LOGS  = `FLOG_MAX_LOGS;
	localparam int PW    = $clog2(REC_DEPTH);
	localparam int FW    = $clog2(REC_DEPTH + 1);
	localparam int CW    = $clog2(CYC_PER_MS);

	typedef struct packed {
		flog_state_type                           st;
		logic [2:0]                               fsync;
		logic                                     fault_lvl;
		logic [CW-1:0]                            cyc_cnt;
		logic [15:0]                              ms_cnt;
		logic                                     pend;
		logic [REC_W-1:0]                         pend_rec;
		logic [REC_DEPTH-1:0][REC_W-1:0]          ring;
		logic [PW-1:0]                            ring_wr;
		logic [FW-1:0]                            ring_fill;
		logic [15:0]                              post_cnt;
		logic [FW-1:0]                            copy_idx;
		logic [31:0]                              cap_time;
		logic [31:0]                              cap_date;
		logic [LOGS-1:0][REC_DEPTH-1:0][REC_W-1:0] logs;
		logic [LOGS-1:0][HDR_W-1:0]               hdr;
		logic [3:0]                               wslot;
		logic [3:0]                               nlogs;
		logic [15:0]                              log_index;
		logic [63:0]                              user_en;
		logic                                     user_mode;
		logic                                     fill_mode;
		logic [REC_W-1:0]                         win;
		logic [31:0]                              rd_data;
		logic                                     stall;
	} flog_regs_type;

	flog_regs_type    r;
	flog_regs_type    n;
	logic             fifo_in_ready;
	logic             fifo_out_valid;
	logic [REC_W-1:0] fifo_out_data;
	logic [REC_W-1:0] masked_rec;
	logic             drain_ok;
	logic             pop;
	logic             fault_tick;
	logic             sample_tick;
	logic             fault_rise;
	logic             sel_valid;
	logic [3:0]       sel_slot;
	logic [HDR_W-1:0] sel_hdr;
	logic [15:0]      sel_count;
	logic [REC_W-1:0] sel_rec;
	logic [REC_W-1:0] copy_src;
	logic [HDR_W-1:0] oldest_hdr;
	logic             hdr_cmd;
	logic             rec_cmd;
	logic             usr_cmd;
	logic             ctrl_wr;
	logic [15:0]      post_target;

	// ==================================================================
	// Helpers
	function automatic logic [3:0] slot_of(input logic [15:0] idx,
		input logic [3:0] ws, input logic [3:0] cnt);
		logic [4:0] s;
		s = (cnt == 4'(LOGS)) ? {1'b0, ws} : 5'h00;
		s = s + idx[4:0];
		if (s >= 5'(LOGS)) s = s - 5'(LOGS);
		return s[3:0];
	endfunction

	// Oldest entry sits at the write pointer once the ring has wrapped
	function automatic logic [PW-1:0] ring_pos(input logic [FW-1:0] k,
		input logic [FW-1:0] fill, input logic [PW-1:0] wr);
		int p;
		p = (int'(fill) == REC_DEPTH) ? int'(wr) : 0;
		p = p + int'(k);
		if (p >= REC_DEPTH) p = p - REC_DEPTH;
		return PW'(p);
	endfunction

	// ==================================================================
	// Submodules
	flog_record_mask u_mask (
		.enable_in  (r.user_en[`FLOG_PARAM_LAST:0]),
		.record_in  (param_words_in),
		.record_out (masked_rec)
	);

	// The ring stops draining while a log is copied, so records back up
	flog_fifo #(.WIDTH(REC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock_in      (clock_in),
		.rst_in        (rst_in),
		.in_valid_in   (r.pend),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (r.pend_rec),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (drain_ok),
		.out_data_out  (fifo_out_data)
	);

	// ==================================================================
	// Decodes
	assign drain_ok    = (r.st == ST_RUN) || (r.st == ST_POST);
	assign pop         = fifo_out_valid && drain_ok;
	assign fault_tick  = (r.cyc_cnt == CW'(CYC_PER_MS - 1))
		&& (r.ms_cnt >= PERIOD_MS - 16'h0001);
	assign sample_tick = r.user_mode ? user_tick_in : fault_tick;
	assign fault_rise  = (r.fsync[1] == r.fsync[2]) && r.fsync[2]
		&& !r.fault_lvl;
	assign sel_valid   = (r.log_index < {12'h000, r.nlogs});
	assign sel_slot    = slot_of(r.log_index, r.wslot, r.nlogs); // RL5
	assign sel_hdr     = r.hdr[sel_slot];
	assign sel_count   = sel_hdr[`FLOG_HDR_COUNT*16 +: 16];
	assign sel_rec     = r.logs[sel_slot][wr_data_in[PW-1:0]];
	assign copy_src    = r.ring[ring_pos(r.copy_idx, r.ring_fill, r.ring_wr)];
	assign oldest_hdr  = r.hdr[r.wslot];
	assign hdr_cmd     = wr_in && (addr_in == `FLOG_ADDR_HDR_FETCH)
		&& (wr_data_in[15:0] == `FLOG_HDR_CMD);
	assign rec_cmd     = wr_in && (addr_in == `FLOG_ADDR_REC_FETCH);
	assign usr_cmd     = wr_in && (addr_in == `FLOG_ADDR_USER_FETCH);
	assign ctrl_wr     = wr_in && (addr_in == `FLOG_ADDR_USER_CTRL);
	assign post_target = r.user_mode ? 16'(USER_POST) : 16'(POST_SAMPLES);

	// ==================================================================
	// Next state
	always_comb begin
		logic [HDR_W-1:0] hw;
		logic [15:0]      nc;
		int               widx;
		hw   = '0;
		nc   = r.post_cnt + (pop ? 16'h0001 : 16'h0000);
		widx = int'(addr_in - `FLOG_ADDR_WIN_BASE);
		n = r;
		n.rd_data = 32'h0000_0000;
		// Fault pin: three stages, a change counts when the last two agree
		n.fsync = {r.fsync[1:0], fault_in};
		if (r.fsync[1] == r.fsync[2]) begin
			n.fault_lvl = r.fsync[2];
		end
		if (r.cyc_cnt == CW'(CYC_PER_MS - 1)) begin
			n.cyc_cnt = '0;
			n.ms_cnt = fault_tick ? 16'h0000 : r.ms_cnt + 16'h0001; // RL1
		end else begin
			n.cyc_cnt = r.cyc_cnt + CW'(1);
		end
		// A tick while the FIFO is full replaces the waiting record
		if (r.pend && fifo_in_ready) begin
			n.pend = 1'b0;
		end
		if (sample_tick) begin
			n.pend = 1'b1; // RL1
			n.pend_rec = r.user_mode ? masked_rec : param_words_in; // RL12
		end
		n.stall = r.pend && !fifo_in_ready;
		if (pop) begin
			n.ring[r.ring_wr] = fifo_out_data; // RL1
			n.ring_wr = (r.ring_wr == PW'(REC_DEPTH - 1)) ? '0
				: r.ring_wr + PW'(1);
			if (r.ring_fill != FW'(REC_DEPTH)) begin
				n.ring_fill = r.ring_fill + FW'(1);
			end
		end
		case (r.st)
			ST_RUN: begin
				if (!r.user_mode && fault_rise) begin
					n.st = ST_POST; // RL2
					n.post_cnt = 16'h0000;
					n.cap_time = rtc_time_in;
					n.cap_date = rtc_date_in;
				end else if (r.user_mode && user_trigger_in) begin
					n.post_cnt = 16'h0000;
					n.st = r.fill_mode ? ST_POST : ST_FROZEN; // RL12
				end
			end
			ST_POST: begin
				n.post_cnt = nc;
				if (nc >= post_target) begin
					n.copy_idx = '0;
					n.st = r.user_mode ? ST_FROZEN : ST_COPY; // RL2 RL12
				end
			end
			ST_COPY: begin
				// One record per cycle, oldest first
				n.logs[r.wslot][r.copy_idx] = copy_src; // RL2 RL9
				n.copy_idx = r.copy_idx + FW'(1);
				if (r.copy_idx + FW'(1) >= r.ring_fill) begin
					hw[`FLOG_HDR_TS_HI*16 +: 16] = {8'h00,
						r.cap_time[23:16]}; // RL7 RL8
					hw[`FLOG_HDR_TS_LO*16 +: 16] = r.cap_time[15:0];
					hw[`FLOG_HDR_DATE_HI*16 +: 16] = r.cap_date[31:16];
					hw[`FLOG_HDR_DATE_LO*16 +: 16] = r.cap_date[15:0];
					hw[`FLOG_HDR_COUNT*16 +: 16] = 16'(r.ring_fill);
					hw[`FLOG_HDR_WPR*16 +: 16] = 16'(`FLOG_WIN_WORDS);
					hw[`FLOG_HDR_PERIOD*16 +: 16] = PERIOD_MS;
					hw[`FLOG_HDR_POST*16 +: 16] = 16'(POST_SAMPLES);
					n.hdr[r.wslot] = hw; // RL7
					n.wslot = (r.wslot == 4'(LOGS - 1)) ? 4'h0
						: r.wslot + 4'h1; // RL3
					if (r.nlogs != 4'(LOGS)) begin
						n.nlogs = r.nlogs + 4'h1; // RL3 RL4
					end
					n.st = ST_RUN;
				end
			end
			ST_FROZEN: begin
				n.st = ST_FROZEN;
			end
			default: begin
				n.st = ST_RUN;
			end
		endcase
		if (wr_in) begin
			case (addr_in)
				`FLOG_ADDR_LOG_INDEX: n.log_index = wr_data_in[15:0]; // RL5
				`FLOG_ADDR_EN_LOW: n.user_en[31:0] = wr_data_in; // RL13
				`FLOG_ADDR_EN_HIGH: n.user_en[63:32] = wr_data_in; // RL13
				`FLOG_ADDR_USER_CTRL: begin
					// Refused mid-copy so a log is never left half written
					if (r.st != ST_COPY) begin
						n.user_mode = wr_data_in[`FLOG_CTRL_USER_BIT];
						n.fill_mode = wr_data_in[`FLOG_CTRL_FILL_BIT];
						if (wr_data_in[`FLOG_CTRL_USER_BIT] != r.user_mode)
						begin
							n.st = ST_RUN;
							n.ring_fill = '0;
							n.ring_wr = '0;
						end
					end
				end
				default: begin
				end
			endcase
		end
		if (hdr_cmd) begin
			n.win = sel_valid ? REC_W'(sel_hdr) : '0; // RL6 RL15
		end
		if (rec_cmd) begin
			n.win = (sel_valid && wr_data_in[15:0] < sel_count) ? sel_rec
				: '0; // RL11 RL15
		end
		if (usr_cmd) begin
			n.win = (r.st == ST_FROZEN
				&& wr_data_in[15:0] < 16'(r.ring_fill))
				? r.ring[ring_pos(wr_data_in[FW-1:0], r.ring_fill, r.ring_wr)]
				: '0; // RL15
		end
		if (rd_in) begin
			if (addr_in >= `FLOG_ADDR_WIN_BASE
				&& widx < `FLOG_WIN_WORDS) begin
				n.rd_data = {16'h0000, r.win[widx*16 +: 16]}; // RL10
			end else begin
				case (addr_in)
					`FLOG_ADDR_SAMPLE_IVL: n.rd_data = {16'h0000, PERIOD_MS};
					`FLOG_ADDR_VALID_CNT: n.rd_data = {28'h0, r.nlogs}; // RL4
					`FLOG_ADDR_LOG_INDEX: n.rd_data = {16'h0000, r.log_index};
					`FLOG_ADDR_EN_LOW: n.rd_data = r.user_en[31:0];
					`FLOG_ADDR_EN_HIGH: n.rd_data = r.user_en[63:32];
					`FLOG_ADDR_USER_CTRL: n.rd_data = {30'h0, r.fill_mode,
						r.user_mode};
					`FLOG_ADDR_STATUS: n.rd_data = {28'h0, r.st};
					default: n.rd_data = 32'h0000_0000;
				endcase
			end
		end
		if (rst_in) begin
			n = '0;
			n.st = ST_RUN;
		end
	end

	always_ff @(posedge clock_in) begin
		r <= n;
	end

	assign rd_data_out      = r.rd_data;
	assign state_out        = r.st;
	assign sample_stall_out = r.stall;

	// ==================================================================
	// Assertions
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	sequence s_fault_seen;
		(r.st == ST_RUN) && !r.user_mode && fault_rise && !ctrl_wr;
	endsequence
	sequence s_high_write;
		wr_in && (addr_in == `FLOG_ADDR_EN_HIGH);
	endsequence
	sequence s_high_read;
		rd_in && (addr_in == `FLOG_ADDR_EN_HIGH);
	endsequence

	a_fault_tick_loads : assert property ( // RL1
		(fault_tick && !r.user_mode)
		|=> r.pend && (r.pend_rec == $past(param_words_in)))
		else $error("fault sample tick did not load a record");
	a_fault_enters_post : assert property ( // RL2
		s_fault_seen |=> (r.st == ST_POST))
		else $error("fault did not start post capture");
	a_copy_freezes_ring : assert property ( // RL2
		(r.st == ST_COPY) |=> $stable(r.ring_wr) && $stable(r.ring_fill))
		else $error("ring moved while a log was copied");
	a_log_count_cap : assert property ( // RL3
		(r.st == ST_COPY && n.st == ST_RUN && r.nlogs == 4'(LOGS))
		|=> (r.nlogs == 4'(LOGS)) && (r.wslot != $past(r.wslot)))
		else $error("full store did not overwrite the oldest log");
	a_count_readback : assert property ( // RL4
		(rd_in && addr_in == `FLOG_ADDR_VALID_CNT)
		|=> rd_data_out == {28'h0, $past(r.nlogs)})
		else $error("log count read back wrong");
	a_oldest_index : assert property ( // RL5
		(hdr_cmd && r.log_index == 16'h0000 && r.nlogs == 4'(LOGS))
		|=> r.win[HDR_W-1:0] == $past(oldest_hdr))
		else $error("index zero did not select the oldest log");
	a_header_window : assert property ( // RL6
		(hdr_cmd && sel_valid) |=> (r.win[HDR_W-1:0] == $past(sel_hdr))
		&& (r.win[REC_W-1:HDR_W] == '0))
		else $error("header fetch loaded wrong window");
	a_header_layout : assert property ( // RL7
		(hdr_cmd && sel_valid) |=> r.win[`FLOG_HDR_WPR*16 +: 16]
		== 16'(`FLOG_WIN_WORDS))
		else $error("header words per record wrong");
	a_time_top_byte : assert property ( // RL8
		(hdr_cmd && sel_valid) |=> r.win[15:8] == 8'h00)
		else $error("time stamp top byte not zero");
	a_oldest_first : assert property ( // RL9
		(r.st == ST_COPY && r.copy_idx == '0
		&& r.ring_fill == FW'(REC_DEPTH)) |-> copy_src == r.ring[r.ring_wr])
		else $error("record zero is not the oldest sample");
	a_record_window : assert property ( // RL11
		(rec_cmd && sel_valid && wr_data_in[15:0] < sel_count)
		|=> r.win == $past(sel_rec))
		else $error("record fetch loaded wrong record");
	a_user_freeze : assert property ( // RL12
		(r.st == ST_RUN && r.user_mode && !r.fill_mode && user_trigger_in
		&& !ctrl_wr) |=> (r.st == ST_FROZEN) ##1 $stable(r.ring_wr))
		else $error("user trigger did not freeze the ring");
	a_enable_high : assert property ( // RL13
		s_high_write ##1 !(wr_in && addr_in == `FLOG_ADDR_EN_HIGH)
		##1 s_high_read |=> rd_data_out == $past(wr_data_in, 3))
		else $error("high enable word read back wrong");
	a_unselected_zero : assert property ( // RL14
		(sample_tick && r.user_mode && !r.user_en[`FLOG_PARAM_LAST])
		|=> r.pend_rec[REC_W-1 -: 16] == 16'h0000)
		else $error("unselected parameter was captured");
	a_window_steady : assert property ( // RL15
		!(hdr_cmd || rec_cmd || usr_cmd) |=> $stable(r.win))
		else $error("window changed without a fetch");
endmodule // flog_top

/* File: pkg/flog_regs.svh */
// Register offsets, field positions and timing counts of the event logger
`ifndef FLOG_REGS_SVH
`define FLOG_REGS_SVH
// ==================================================================
// Register offsets (word addresses on the register port)
`define FLOG_ADDR_SAMPLE_IVL 16'hA23D
`define FLOG_ADDR_VALID_CNT  16'hA23E
`define FLOG_ADDR_LOG_INDEX  16'hA241
`define FLOG_ADDR_HDR_FETCH  16'hA242
`define FLOG_ADDR_REC_FETCH  16'hA243
`define FLOG_ADDR_EN_LOW     16'hA248
`define FLOG_ADDR_EN_HIGH    16'hA24A
`define FLOG_ADDR_USER_CTRL  16'hA24C
`define FLOG_ADDR_USER_FETCH 16'hA24D
`define FLOG_ADDR_STATUS     16'hA24E
`define FLOG_ADDR_WIN_BASE   16'hA264
// ==================================================================
// Layout of a record, of the header and of the control word
`define FLOG_WIN_WORDS   61
`define FLOG_MAX_LOGS    12
`define FLOG_PARAM_LAST  55
`define FLOG_HDR_WORDS   8
`define FLOG_HDR_TS_HI   0
`define FLOG_HDR_TS_LO   1
`define FLOG_HDR_DATE_HI 2
`define FLOG_HDR_DATE_LO 3
`define FLOG_HDR_COUNT   4
`define FLOG_HDR_WPR     5
`define FLOG_HDR_PERIOD  6
`define FLOG_HDR_POST    7
`define FLOG_W_WARN      3
`define FLOG_W_FFAULT    54
`define FLOG_W_LAST      60
`define FLOG_CTRL_USER_BIT 0
`define FLOG_CTRL_FILL_BIT 1
`define FLOG_HDR_CMD     16'h0001
// ==================================================================
// Timing: one millisecond at a 4 ns clock
`define FLOG_CLK_NS      4
`define FLOG_MS_NS       1000000
`define FLOG_CYC_PER_MS  (`FLOG_MS_NS / `FLOG_CLK_NS)
`define FLOG_PERIOD_MS   16'h0001
`define FLOG_REC_DEPTH   8
`define FLOG_POST        4
`endif

/* File: pkg/flog_pkg.sv */
// Types shared by the event logger modules
package flog_pkg;
	typedef enum logic [3:0] {
		ST_RUN    = 4'b0001,
		ST_POST   = 4'b0010,
		ST_COPY   = 4'b0100,
		ST_FROZEN = 4'b1000
	} flog_state_type;
endpackage

/* File: src/flog_fifo.sv */
// Record FIFO between the sampler and the ring buffer
`timescale 1ns/1ps
module flog_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic             clock_in,
	input  wire logic             rst_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               rp;
		logic [AW-1:0]               wp;
		logic [AW:0]                 cnt;
	} flog_fifo_type;
	flog_fifo_type r;
	flog_fifo_type n;
	logic          push;
	logic          pop;
	assign in_ready_out  = (r.cnt != (AW+1)'(DEPTH));
	assign out_valid_out = (r.cnt != '0);
	assign out_data_out  = r.mem[r.rp];
	assign push = in_valid_in && in_ready_out;
	assign pop  = out_valid_out && out_ready_in;
	always_comb begin
		n = r;
		if (push) begin
			n.mem[r.wp] = in_data_in;
			n.wp = (r.wp == AW'(DEPTH-1)) ? '0 : r.wp + AW'(1);
		end
		if (pop) begin
			n.rp = (r.rp == AW'(DEPTH-1)) ? '0 : r.rp + AW'(1);
		end
		if (push && !pop) begin
			n.cnt = r.cnt + (AW+1)'(1);
		end else if (pop && !push) begin
			n.cnt = r.cnt - (AW+1)'(1);
		end
		if (rst_in) begin
			n = '0;
		end
	end
	always_ff @(posedge clock_in) begin
		r <= n;
	end
endmodule // flog_fifo

/* File: src/flog_record_mask.sv */
// Clears the record words of parameters not enabled for user capture
`timescale 1ns/1ps
`include "flog_regs.svh"
module flog_record_mask (
	input  wire logic [`FLOG_PARAM_LAST:0]       enable_in,
	input  wire logic [`FLOG_WIN_WORDS*16-1:0]   record_in,
	output logic      [`FLOG_WIN_WORDS*16-1:0]   record_out
);
	// Parameter number owning a window word; wide parameters take two
	function automatic int word_param(input int w);
		if (w == 0) return 0;
		if (w < `FLOG_W_WARN + 2) return 1 + (w - 1) / 2;
		if (w < `FLOG_W_FFAULT) return w - 2;
		if (w < `FLOG_W_LAST) return `FLOG_W_FFAULT - 2 + (w - `FLOG_W_FFAULT) / 2;
		return w - 5;
	endfunction
	for (genvar w = 0; w < `FLOG_WIN_WORDS; w++) begin : g_word
		localparam int P = word_param(w);
		// Only enable bits up to the last parameter exist here
		assign record_out[16*w +: 16] =
			enable_in[P] ? record_in[16*w +: 16] : 16'h0000; // RL10 RL14
	end
endmodule // flog_record_mask

/* File: tb/flog_top_tb_top.sv */
// Self-checking testbench of the event logger
`timescale 1ns/1ps
`include "flog_regs.svh"
`define CHK(nm, ex, got) begin \
	cmp_count++; \
	if ((got) !== (ex)) begin \
		miscompares++; \
		$display("Error %s expected %0h seen %0h", nm, ex, got); \
	end \
end
module flog_top_tb_top;
	import flog_pkg::*;
	localparam int DEPTH = 8;
	localparam int POST  = 4;
	logic                          clock_in        = 1'b0;
	logic                          rst_in          = 1'b1;
	logic [15:0]                   addr_in         = 16'h0000;
	logic [31:0]                   wr_data_in      = 32'h0000_0000;
	logic                          wr_in           = 1'b0;
	logic                          rd_in           = 1'b0;
	logic [31:0]                   rd_data_out;
	logic [`FLOG_WIN_WORDS*16-1:0] param_words_in  = '0;
	logic [31:0]                   rtc_time_in     = 32'h0000_0000;
	logic [31:0]                   rtc_date_in     = 32'h0000_0000;
	logic                          fault_in        = 1'b0;
	logic                          user_tick_in    = 1'b0;
	logic                          user_trigger_in = 1'b0;
	flog_state_type                state_out;
	logic                          sample_stall_out;
	int                            miscompares     = 0;
	int                            cmp_count       = 0;
	logic [15:0]                   lfsr            = 16'h0059;
	logic [31:0]                   tv;
	logic [31:0]                   dv;
	logic [63:0]                   tq[$];
	flog_top #(.REC_DEPTH(DEPTH), .POST_SAMPLES(POST), .CYC_PER_MS(4)) i_dut (
		.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
		.rd_data_out(rd_data_out), .param_words_in(param_words_in),
		.rtc_time_in(rtc_time_in), .rtc_date_in(rtc_date_in),
		.fault_in(fault_in), .user_tick_in(user_tick_in),
		.user_trigger_in(user_trigger_in), .state_out(state_out),
		.sample_stall_out(sample_stall_out));
	always #2 clock_in = ~clock_in;
	// ==========================================================
	// Helpers
	task automatic next_rnd(output logic [31:0] v);
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		v[31:16] = lfsr;
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		v[15:0] = lfsr;
	endtask
	// Parameter number that owns window word k
	function automatic int pnum(input int k);
		if (k < 3) return (k + 1) / 2;
		if (k < 5) return 2;
		if (k < 54) return k - 2;
		if (k == 60) return 55;
		return 52 + (k - 54) / 2;
	endfunction
	task automatic stop_test();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask
	task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 d = rd_data_out;
	endtask
	task automatic wait_state(input flog_state_type s, input int lim);
		int n;
		n = 0;
		while (state_out !== s && n < lim) begin
			@(posedge clock_in);
			#1 n++;
		end
		if (state_out !== s) begin
			miscompares++;
			stop_test();
		end
	endtask
	task automatic do_fault();
		next_rnd(tv);
		next_rnd(dv);
		@(posedge clock_in);
		rtc_time_in <= tv;
		rtc_date_in <= dv;
		fault_in <= 1'b1;
		tq.push_back({tv, dv});
		if (tq.size() > 12) void'(tq.pop_front());
		wait_state(ST_POST, 40);
		@(posedge clock_in);
		fault_in <= 1'b0;
		wait_state(ST_RUN, 400);
		// Let the ring refill before the next fault
		repeat (40) @(posedge clock_in);
	endtask
	task automatic check_hdr(input int idx, input int n);
		logic [31:0] r;
		logic [15:0] e[8];
		e = '{{8'h00, tq[idx][55:48]}, tq[idx][47:32], tq[idx][31:16],
			tq[idx][15:0], 16'(DEPTH), 16'(`FLOG_WIN_WORDS), 16'h0001,
			16'(POST)};
		reg_wr(`FLOG_ADDR_LOG_INDEX, 32'(idx));
		reg_wr(`FLOG_ADDR_HDR_FETCH, 32'h0000_0001);
		for (int k = 0; k < n; k++) begin
			reg_rd(`FLOG_ADDR_WIN_BASE + 16'(k), r);
			`CHK("header word", {16'h0000, e[k]}, r)
		end
	endtask
	task automatic check_win(input logic [63:0] msk);
		logic [31:0] r;
		logic [15:0] e;
		for (int k = 0; k < `FLOG_WIN_WORDS; k++) begin
			e = msk[pnum(k)] ? param_words_in[16*k +: 16] : 16'h0000;
			reg_rd(`FLOG_ADDR_WIN_BASE + 16'(k), r);
			`CHK("window word", {16'h0000, e}, r)
		end
	endtask
	task automatic user_ticks(input int cnt);
		repeat (cnt) begin
			@(posedge clock_in);
			user_tick_in <= 1'b1;
			@(posedge clock_in);
			user_tick_in <= 1'b0;
			repeat (4) @(posedge clock_in);
		end
	endtask
	task automatic user_trig();
		@(posedge clock_in);
		user_trigger_in <= 1'b1;
		@(posedge clock_in);
		user_trigger_in <= 1'b0;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] r;
		logic [63:0] en;
		for (int k = 0; k < `FLOG_WIN_WORDS; k++) begin
			next_rnd(tv);
			param_words_in[16*k +: 16] <= tv[15:0];
		end
		repeat (16) @(posedge clock_in);
		rst_in <= 1'b0;
		reg_rd(`FLOG_ADDR_VALID_CNT, r);
		`CHK("log count", 32'h0000_0000, r)
		reg_rd(`FLOG_ADDR_SAMPLE_IVL, r);
		`CHK("sample period", 32'h0000_0001, r)
		`CHK("stall", 1'b0, sample_stall_out)
		reg_rd(16'hA240, r);
		`CHK("unmapped", 32'h0000_0000, r)
		repeat (100) @(posedge clock_in);
		do_fault();
		reg_rd(`FLOG_ADDR_VALID_CNT, r);
		`CHK("log count", 32'h0000_0001, r)
		check_hdr(0, 8);
		reg_wr(`FLOG_ADDR_REC_FETCH, 32'h0000_0000);
		check_win('1);
		reg_wr(`FLOG_ADDR_REC_FETCH, 32'(DEPTH - 1));
		check_win('1);
		reg_wr(`FLOG_ADDR_REC_FETCH, 32'(DEPTH));
		check_win('0);
		// A header fetch that does not write one is ignored
		reg_wr(`FLOG_ADDR_HDR_FETCH, 32'h0000_0002);
		check_win('0);
		reg_wr(`FLOG_ADDR_LOG_INDEX, 32'h0000_0001);
		reg_wr(`FLOG_ADDR_HDR_FETCH, 32'h0000_0001);
		check_win('0);
		// Thirteen faults in all: the first one must be overwritten
		repeat (12) do_fault();
		reg_rd(`FLOG_ADDR_VALID_CNT, r);
		`CHK("log count", 32'h0000_000C, r)
		for (int i = 0; i < 12; i++) check_hdr(i, 4);
		reg_wr(`FLOG_ADDR_USER_CTRL, 32'h0000_0001);
		next_rnd(en[31:0]);
		next_rnd(en[63:32]);
		en[63:56] = 8'hFF;
		reg_wr(`FLOG_ADDR_EN_LOW, en[31:0]);
		reg_wr(`FLOG_ADDR_EN_HIGH, en[63:32]);
		reg_rd(`FLOG_ADDR_EN_LOW, r);
		`CHK("enable low", en[31:0], r)
		reg_rd(`FLOG_ADDR_EN_HIGH, r);
		`CHK("enable high", en[63:32], r)
		user_ticks(3);
		user_trig();
		wait_state(ST_FROZEN, 20);
		`CHK("state", ST_FROZEN, state_out)
		reg_wr(`FLOG_ADDR_USER_FETCH, 32'h0000_0002);
		check_win(en);
		// Frozen ring: ticks back up the FIFO until the sampler stalls
		user_ticks(6);
		#1 `CHK("stall", 1'b1, sample_stall_out)
		reg_wr(`FLOG_ADDR_USER_FETCH, 32'h0000_0000);
		check_win(en);
		// Fill mode: the trigger leads through post capture to frozen
		reg_wr(`FLOG_ADDR_USER_CTRL, 32'h0000_0000);
		reg_wr(`FLOG_ADDR_USER_CTRL, 32'h0000_0003);
		repeat (20) @(posedge clock_in);
		user_trig();
		wait_state(ST_POST, 20);
		reg_rd(`FLOG_ADDR_STATUS, r);
		`CHK("status", 32'h0000_0002, r)
		reg_wr(`FLOG_ADDR_USER_FETCH, 32'h0000_0000);
		check_win('0);
		user_ticks(6);
		wait_state(ST_FROZEN, 40);
		`CHK("state", ST_FROZEN, state_out)
		stop_test();
	end
endmodule // flog_top_tb_top
